// ===== mcu_clock_generation.sv
// Design decision made here: register access over APB.
`timescale 1ns/10ps
// Overview of operation
// (RQ1) Machine cycle equals two CPU clock cycles
// (RQ2) Peripheral clock runs at half CPU clock
// (RQ3) One of four sources feeds the divider
// (RQ4) Source chosen by configuration, not register
// (RQ5) Crystal offers low, medium, high ranges
// (RQ6) Above 12 MHz board must hold reset
// (RQ7) Clock output only when crystal unused
// (RQ8) Clock output driven only while enable set
// (RQ9) Clock output toggles at half CPU clock
// (RQ10) Six-bit trim loads factory value, writable
// (RQ11) Only power-on reset reloads the trim
// (RQ12) Watchdog oscillator selectable as low-power source
// (RQ13) External clock taken from crystal input pin
// (RQ14) Trim register bits: select, enable, trim
// (RQ15) Software clears output enable before idle
// (RQ16) Divider ratio up to 510, changeable anytime
// (RQ17) Wake-up gates CPU clock 992/224 cycles plus settling
// (RQ18) Clock output from toggle, glitch-free start/stop; the stop forced when rtc_uses_crystal rises cuts a high level at once
module mcu_clock_generation
	import clock_gen_pkg::*;
#(
	parameter int SETTLE_CYCLES = SETTLE_CYCLES_DEF,
	parameter logic [5:0] TRIM_FACTORY = 6'h20
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic por_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] source_config,
	input wire logic [1:0] crystal_range_config,
	input wire logic rtc_uses_crystal,
	input wire logic watchdog_osc_in,
	input wire logic internal_rc_clock,
	input wire logic crystal_osc_in,
	input wire logic crystal_in_pin,
	input wire logic wake_request,
	output logic selected_source_clock,
	output logic cpu_core_clock,
	output logic cpu_clock_tick,
	output logic machine_cycle_tick,
	output logic peripheral_clock,
	output logic peripheral_clock_tick,
	output logic crystal_out_clock_pin_o,
	output logic crystal_out_clock_pin_oe,
	output logic [1:0] crystal_range,
	output logic crystal_osc_enable,
	output logic [5:0] rc_trim,
	output logic rc_clock_select,
	output logic cpu_clock_held
);

	// All state reset by the ordinary reset: range loads RANGE_UNUSED, the rest is cleared
	typedef struct packed {
		logic cfg_done;
		source_type src;
		range_type range;
		logic [7:0] divider;
		logic [8:0] div_cnt;
		logic cpu_tick;
		logic cpu_clk;
		logic mach_phase;
		logic mach_tick;
		logic per_clk;
		logic per_tick;
		logic clkout_act;
		logic clkout_lvl;
		wake_type wake;
		logic [9:0] wake_cnt;
		logic [SETTLE_WIDTH-1:0] settle_cnt;
		logic [31:0] rdata;
		logic err;
	} clk_state_type;

	clk_state_type st_r;
	clk_state_type st_nxt;

	// Trim register lives apart: only power-on reset touches it
	logic [7:0] tune_r;
	logic [7:0] tune_nxt;

	// Synchronised oscillator levels and edges
	logic [3:0] src_level;
	logic [3:0] src_rise;
	logic osc_tick;
	logic osc_level;
	logic setup_phase;
	logic access_phase;
	logic hit_tune;
	logic hit_div;
	logic hit_stat;
	logic clkout_allowed;
	logic [8:0] div_limit_now;
	logic [7:0] status_byte;

	// Division limit in oscillator ticks: 1 for ratio 0, else twice the ratio
	function automatic logic [8:0] div_limit(input logic [7:0] ratio);
		if (ratio == 8'h00) begin
			div_limit = 9'd1;
		end else begin
			div_limit = {ratio, 1'b0};
		end
	endfunction

	// Wake count for the captured source
	function automatic logic [9:0] wake_len(input source_type s);
		if (s == SRC_CRYSTAL) begin
			wake_len = WAKE_XTAL_OSC_CYCLES;
		end else begin
			wake_len = WAKE_OTHER_OSC_CYCLES;
		end
	endfunction

	// Sources are free-running and unrelated to pclk, so each one
	// passes its own three-stage filter before any edge is used
	// One synchroniser per oscillator source, indexed by source code
	pin_sync u_sync_wdog (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(watchdog_osc_in),
		.level(src_level[0]),
		.rise(src_rise[0])
	);
	pin_sync u_sync_rc (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(internal_rc_clock),
		.level(src_level[1]),
		.rise(src_rise[1])
	);
	pin_sync u_sync_xtal (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(crystal_osc_in),
		.level(src_level[2]),
		.rise(src_rise[2])
	);
	pin_sync u_sync_ext (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(crystal_in_pin),
		.level(src_level[3]),
		.rise(src_rise[3])
	);

	// Source multiplexer, quiet until the configuration is captured
	always_comb begin
		osc_tick = st_r.cfg_done & src_rise[st_r.src]; // RQ3 RQ12 RQ13
		osc_level = st_r.cfg_done & src_level[st_r.src];
	end

	// Bus decode helpers
	always_comb begin
		setup_phase = psel & ~penable;
		access_phase = psel & penable;
		hit_tune = (paddr == reg_addr(TUNE_INDEX));
		hit_div = (paddr == reg_addr(DIVIDER_INDEX));
		hit_stat = (paddr == reg_addr(STATUS_INDEX));
		div_limit_now = div_limit(st_r.divider);
		// Output pin free only when neither system nor RTC use the crystal
		clkout_allowed = st_r.cfg_done & (st_r.src != SRC_CRYSTAL) & ~rtc_uses_crystal; // RQ7
		status_byte = 8'h00;
		status_byte[STAT_SRC_LSB +: 2] = st_r.src;
		status_byte[STAT_RANGE_LSB +: 2] = st_r.range;
		status_byte[STAT_WAKE_BIT] = (st_r.wake != WAKE_IDLE);
		status_byte[STAT_CLKOUT_BIT] = st_r.clkout_act;
		status_byte[STAT_CFG_BIT] = st_r.cfg_done;
	end

	// Next-state logic for clocks, wake-up and bus
	always_comb begin
		st_nxt = st_r;
		st_nxt.cpu_tick = 1'b0;
		st_nxt.mach_tick = 1'b0;
		st_nxt.per_tick = 1'b0;

		// Capture the programmed configuration once after reset release
		// The straps are read once; a later change needs a new reset
		if (!st_r.cfg_done) begin
			st_nxt.cfg_done = 1'b1;
			st_nxt.src = source_type'(source_config); // RQ4
			if (source_type'(source_config) == SRC_CRYSTAL) begin
				st_nxt.range = range_type'(crystal_range_config); // RQ5
			end else begin
				st_nxt.range = RANGE_UNUSED;
			end
			// Start-up behaves like a wake-up from the new source
			st_nxt.wake = WAKE_OSC;
			st_nxt.wake_cnt = wake_len(source_type'(source_config));
		end

		// Wake-up sequencer gates the CPU clock
		case (st_r.wake)
			WAKE_IDLE: begin
				if (wake_request && st_r.cfg_done) begin
					st_nxt.wake = WAKE_OSC; // RQ17
					st_nxt.wake_cnt = wake_len(st_r.src); // RQ17
				end
			end
			WAKE_OSC: begin
				// Count oscillator cycles, then the fixed settling time
				// Settling is counted in pclk cycles, not oscillator cycles
				if (osc_tick) begin
					if (st_r.wake_cnt <= 10'd1) begin
						st_nxt.wake = WAKE_SETTLE; // RQ17
						st_nxt.settle_cnt = SETTLE_WIDTH'(SETTLE_CYCLES);
					end else begin
						st_nxt.wake_cnt = st_r.wake_cnt - 10'd1;
					end
				end
			end
			WAKE_SETTLE: begin
				if (st_r.settle_cnt <= SETTLE_WIDTH'(1)) begin
					st_nxt.wake = WAKE_IDLE; // RQ17
					st_nxt.settle_cnt = '0;
				end else begin
					st_nxt.settle_cnt = st_r.settle_cnt - SETTLE_WIDTH'(1);
				end
			end
			default: begin
				st_nxt.wake = WAKE_IDLE;
			end
		endcase

		// Divider: the compare uses >= so a smaller new ratio never stalls
		// A ratio change acts at the next count and never stops the CPU
		if (osc_tick && st_r.wake == WAKE_IDLE) begin
			if ((st_r.div_cnt + 9'd1) >= div_limit_now) begin
				st_nxt.div_cnt = '0; // RQ16
				st_nxt.cpu_tick = 1'b1; // RQ3
			end else begin
				st_nxt.div_cnt = st_r.div_cnt + 9'd1; // RQ16
			end
		end

		// Derived clocks advance on each CPU tick
		if (st_r.cpu_tick) begin
			st_nxt.cpu_clk = ~st_r.cpu_clk;
			st_nxt.mach_phase = ~st_r.mach_phase;
			st_nxt.mach_tick = st_r.mach_phase; // RQ1
			st_nxt.per_clk = ~st_r.per_clk; // RQ2
			st_nxt.per_tick = st_r.mach_phase; // RQ2
			// Toggle output; an enable-driven stop comes only from the low level, so no runt pulse
			if (st_r.clkout_act) begin
				st_nxt.clkout_lvl = ~st_r.clkout_lvl; // RQ9 RQ18
			end
		end

		// Start and enable-driven stop of the clock output at a low level only; losing clkout_allowed stops it at once
		// Dropping the enable while the pin is high would leave a short pulse,
		// so the enable is only taken over while the pin is low
		if (!st_r.clkout_lvl && !(st_r.cpu_tick && st_r.clkout_act)) begin
			st_nxt.clkout_act = tune_r[TUNE_CLKOUT_EN_BIT] & clkout_allowed; // RQ8 RQ18
		end
		if (!clkout_allowed) begin
			st_nxt.clkout_act = 1'b0; // RQ7
			st_nxt.clkout_lvl = 1'b0;
		end

		// Divider ratio written by software at any time
		if (access_phase && pwrite && hit_div) begin
			st_nxt.divider = pwdata[7:0]; // RQ16
		end

		// Read data captured in the setup phase
		if (setup_phase) begin
			st_nxt.err = ~(hit_tune | hit_div | hit_stat);
			st_nxt.rdata = READ_ZERO;
			if (!pwrite) begin
				if (hit_tune) begin
					st_nxt.rdata[7:0] = tune_r; // RQ14
				end else if (hit_div) begin
					st_nxt.rdata[7:0] = st_r.divider;
				end else if (hit_stat) begin
					st_nxt.rdata[7:0] = status_byte;
				end
			end
		end
	end

	// Trim register next value
	always_comb begin
		tune_nxt = tune_r;
		if (access_phase && pwrite && hit_tune) begin
			tune_nxt = pwdata[7:0]; // RQ10 RQ14
		end
	end

	// Main state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
			st_r.src <= SRC_WATCHDOG;
			st_r.range <= RANGE_UNUSED;
			st_r.divider <= DIVIDER_RESET;
			st_r.wake <= WAKE_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Warm resets leave the trim alone, so a frequency set by software
	// survives a watchdog, software, external or brownout reset
	// Trim register: reloaded by power-on reset only
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			tune_r <= {2'b00, TRIM_FACTORY}; // RQ10 RQ11
		end else begin
			tune_r <= tune_nxt; // RQ11
		end
	end

	// Read data is registered in the setup cycle, so it already stands
	// through the whole access cycle and no wait state is needed
	// Bus answers: zero wait states, error on unmapped address
	assign pready = 1'b1;
	assign prdata = st_r.rdata;
	assign pslverr = st_r.err & access_phase;

	// Clock outputs; the CPU clock stays held until the straps are captured
	assign selected_source_clock = osc_level;
	assign cpu_core_clock = st_r.cpu_clk;
	assign cpu_clock_tick = st_r.cpu_tick;
	assign machine_cycle_tick = st_r.mach_tick; // RQ1
	assign peripheral_clock = st_r.per_clk; // RQ2
	assign peripheral_clock_tick = st_r.per_tick;
	assign crystal_out_clock_pin_o = st_r.clkout_lvl;
	assign crystal_out_clock_pin_oe = st_r.clkout_act; // RQ8
	assign crystal_range = st_r.range; // RQ5
	assign crystal_osc_enable = st_r.cfg_done & ((st_r.src == SRC_CRYSTAL) | rtc_uses_crystal);
	assign rc_trim = tune_r[TUNE_TRIM_MSB:TUNE_TRIM_LSB]; // RQ10
	assign rc_clock_select = tune_r[TUNE_RC_SEL_BIT]; // RQ14
	assign cpu_clock_held = (st_r.wake != WAKE_IDLE) | ~st_r.cfg_done; // RQ17

endmodule // mcu_clock_generation

// ===== clock_gen_pkg.sv
package clock_gen_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] TUNE_INDEX = 8'h96;
	localparam logic [7:0] DIVIDER_INDEX = 8'h95;
	localparam logic [7:0] STATUS_INDEX = 8'h97;

	// Tuning register field positions
	localparam int TUNE_RC_SEL_BIT = 7;
	localparam int TUNE_CLKOUT_EN_BIT = 6;
	localparam int TUNE_TRIM_MSB = 5;
	localparam int TUNE_TRIM_LSB = 0;
	localparam int TRIM_WIDTH = 6;

	// Status register field positions
	localparam int STAT_SRC_LSB = 0;
	localparam int STAT_RANGE_LSB = 2;
	localparam int STAT_WAKE_BIT = 4;
	localparam int STAT_CLKOUT_BIT = 5;
	localparam int STAT_CFG_BIT = 6;

	// Reset values
	localparam logic [7:0] DIVIDER_RESET = 8'h00;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

	// Wake-up counts in oscillator cycles
	localparam logic [9:0] WAKE_XTAL_OSC_CYCLES = 10'd992;
	localparam logic [9:0] WAKE_OTHER_OSC_CYCLES = 10'd224;

	// Fixed settling time after the oscillator count
	localparam int CLK_FREQ_MHZ = 200;
	localparam int SETTLE_TIME_NS = 60000;
	localparam int SETTLE_CYCLES_DEF = (SETTLE_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int SETTLE_WIDTH = 16;

	// Oscillator source chosen at flash programming time
	typedef enum logic [1:0] {
		SRC_WATCHDOG = 2'b00,
		SRC_RC = 2'b01,
		SRC_CRYSTAL = 2'b10,
		SRC_EXTERNAL = 2'b11
	} source_type;

	// Crystal frequency range
	typedef enum logic [1:0] {
		RANGE_LOW = 2'b00,
		RANGE_MEDIUM = 2'b01,
		RANGE_HIGH = 2'b10,
		RANGE_UNUSED = 2'b11
	} range_type;

	// Wake-up sequencer states
	typedef enum logic [1:0] {
		WAKE_IDLE = 2'b00,
		WAKE_OSC = 2'b01,
		WAKE_SETTLE = 2'b10
	} wake_type;

	// Byte address of a register index
	function automatic logic [11:0] reg_addr(input logic [7:0] index);
		reg_addr = {2'b00, index, 2'b00};
	endfunction

endpackage

// ===== pin_sync.sv
`timescale 1ns/10ps
module pin_sync
	import clock_gen_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic async_in,
	output logic level,
	output logic rise
);

	// Three stage chain plus filtered level and edge pulse
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
		logic rise;
	} sync_state_type;

	sync_state_type st_r;
	sync_state_type st_nxt;

	// Level changes only once the second and third stages agree
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = async_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		st_nxt.rise = 1'b0;
		if (st_r.s2 == st_r.s3) begin
			st_nxt.lvl = st_r.s3;
			st_nxt.rise = st_r.s3 & ~st_r.lvl;
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign level = st_r.lvl;
	assign rise = st_r.rise;

endmodule // pin_sync

// ===== clock_gen_properties.sv
`timescale 1ns/10ps
// Port-level checks of the clock block
module clock_gen_properties #(
	parameter logic [5:0] TRIM_FACTORY = 6'h20
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic por_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic rtc_uses_crystal,
	input wire logic wake_request,
	input wire logic cpu_core_clock,
	input wire logic cpu_clock_tick,
	input wire logic machine_cycle_tick,
	input wire logic crystal_out_clock_pin_o,
	input wire logic crystal_out_clock_pin_oe,
	input wire logic [5:0] rc_trim,
	input wire logic cpu_clock_held
);
	// Write access to the tuning register
	wire tune_wr = psel && penable && pwrite && (paddr == 12'h258);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_acc;
		psel && penable;
	endsequence
	chk_ready_zero: assert property (s_acc |-> pready)
		else $error("access without ready");
	chk_upper_zero: assert property (s_acc |-> prdata[31:8] == 24'h00_0000)
		else $error("upper read bits set");
	chk_trim_write: assert property (disable iff (!por_n || !presetn)
		tune_wr |=> rc_trim == $past(pwdata[5:0])) else $error("trim not written");
	chk_trim_kept: assert property (disable iff (!por_n) !tune_wr |=> $stable(rc_trim))
		else $error("trim changed without write");
	chk_por_load: assert property (disable iff (!por_n)
		$rose(por_n) |-> rc_trim == TRIM_FACTORY) else $error("trim not reloaded");
	chk_core_tick: assert property ($changed(cpu_core_clock) == $past(cpu_clock_tick))
		else $error("core clock off its tick");
	chk_mc_pair: assert property (machine_cycle_tick |-> $past(cpu_clock_tick))
		else $error("machine tick without cpu tick");
	chk_wake_held: assert property (wake_request |-> ##[1:2] cpu_clock_held)
		else $error("wake did not hold clock");
	chk_oe_low: assert property ($rose(crystal_out_clock_pin_oe) |-> !crystal_out_clock_pin_o)
		else $error("clock out started high");
	chk_rtc_block: assert property (rtc_uses_crystal |-> ##[1:2] !crystal_out_clock_pin_oe)
		else $error("clock out while crystal busy");
endmodule // clock_gen_properties

// ===== osc_model.sv
`timescale 1ns/10ps
// Free-running sources, each slower than pclk/8, edges kept off pclk edges
module osc_model (
	output logic watchdog_osc_in,
	output logic internal_rc_clock,
	output logic crystal_osc_in,
	output logic crystal_in_pin
);
	initial begin watchdog_osc_in = 1'b0; #2; forever #30 watchdog_osc_in = ~watchdog_osc_in; end
	initial begin internal_rc_clock = 1'b0; #2; forever #25 internal_rc_clock = ~internal_rc_clock; end
	initial begin crystal_osc_in = 1'b0; #2; forever #35 crystal_osc_in = ~crystal_osc_in; end
	initial begin crystal_in_pin = 1'b0; #2; forever #40 crystal_in_pin = ~crystal_in_pin; end
endmodule // osc_model

// ===== tb.sv
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module tb;
	import clock_gen_pkg::*;
	logic pclk, presetn, por_n, psel, penable, pwrite, rtc_uses_crystal, wake_request, pready;
	logic pslverr, selected_source_clock, cpu_core_clock, cpu_clock_tick, machine_cycle_tick;
	logic peripheral_clock, peripheral_clock_tick, crystal_osc_enable, rc_clock_select;
	logic crystal_out_clock_pin_o, crystal_out_clock_pin_oe, cpu_clock_held;
	logic watchdog_osc_in, internal_rc_clock, crystal_osc_in, crystal_in_pin;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [1:0] source_config, crystal_range_config, crystal_range;
	logic [5:0] rc_trim;
	int bad_count = 0, cmp_count = 0;
	int per [4] = '{12, 10, 14, 16};
	localparam logic [11:0] TUNE_A = 12'h258, DIV_A = 12'h254, STAT_A = 12'h25C;
	mcu_clock_generation #(.SETTLE_CYCLES(4)) u_mcu_clock_generation (.*);
	osc_model u_osc_model (.*);
	initial begin pclk = 1'b0; forever #2.5 pclk = ~pclk; end
	// Full run is about 0.42 ms of simulated time; limit 100000 cycles
	initial begin #500_000; bad_count++; tally_and_finish(); end
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// One APB transfer, held until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata; e = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r; logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r; logic e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		`CHK(r, x)
		`CHK(e, xe)
	endtask
	task automatic do_reset(input logic p);
		@(posedge pclk);
		presetn <= 1'b0; por_n <= !p;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1; por_n <= 1'b1;
		repeat (2) @(posedge pclk);
	endtask
	// Cycles until the CPU clock is released, compared with the wake span
	task automatic wake_len(input int w, input int p);
		int n = 0;
		while (cpu_clock_held !== 1'b0 && n < 20000) begin @(posedge pclk); n++; end
		`CHK(n >= (w - 1) * p && n <= w * p + p + 16, 1'b1)
	endtask
	task automatic tick_gap(output int n);
		@(posedge pclk); while (cpu_clock_tick !== 1'b1) @(posedge pclk);
		@(posedge pclk); n = 1; while (cpu_clock_tick !== 1'b1) begin @(posedge pclk); n++; end
	endtask
	// Cycles between two rising levels of the selected source clock
	task automatic src_gap(output int n);
		@(posedge pclk); while (selected_source_clock !== 1'b0) @(posedge pclk);
		while (selected_source_clock !== 1'b1) @(posedge pclk);
		n = 0; while (selected_source_clock !== 1'b0) begin @(posedge pclk); n++; end
		while (selected_source_clock !== 1'b1) begin @(posedge pclk); n++; end
	endtask
	task automatic t_regs();
		wake_len(224, 10);
		rd(TUNE_A, 32'h0000_0020, 1'b0);
		wr(TUNE_A, 32'hFFFF_FF85);
		rd(TUNE_A, 32'h0000_0085, 1'b0);
		`CHK({rc_clock_select, rc_trim}, 7'h45)
		rd(12'h000, 32'h0000_0000, 1'b1);
		wr(TUNE_A, 32'h0000_003A);
		do_reset(1'b0);
		rd(TUNE_A, 32'h0000_003A, 1'b0);
		do_reset(1'b1);
		rd(TUNE_A, 32'h0000_0020, 1'b0);
		wake_len(224, 10);
	endtask
	task automatic t_clkout();
		int t = 0, k = 0, m = 0, q = 0, n = 0, u = 0;
		logic p, pc;
		`CHK(crystal_out_clock_pin_oe, 1'b0)
		wr(TUNE_A, 32'h0000_0060);
		while (crystal_out_clock_pin_oe !== 1'b1 && n < 200) begin @(posedge pclk); n++; end
		p = crystal_out_clock_pin_o;
		pc = peripheral_clock;
		repeat (400) begin
			@(posedge pclk);
			t += (crystal_out_clock_pin_o !== p);
			u += (peripheral_clock !== pc);
			p = crystal_out_clock_pin_o;
			pc = peripheral_clock;
			k += cpu_clock_tick; m += machine_cycle_tick; q += peripheral_clock_tick;
		end
		`CHK(crystal_out_clock_pin_oe, 1'b1)
		`CHK(t >= k - 1 && t <= k + 1, 1'b1)
		`CHK(2 * m >= k - 2 && 2 * m <= k + 2, 1'b1)
		`CHK(2 * q >= k - 2 && 2 * q <= k + 2, 1'b1)
		`CHK(u >= k - 1 && u <= k + 1, 1'b1)
		rtc_uses_crystal <= 1'b1;
		repeat (3) @(posedge pclk);
		`CHK(crystal_out_clock_pin_oe, 1'b0)
		`CHK(crystal_osc_enable, 1'b1)
		rtc_uses_crystal <= 1'b0;
		n = 0;
		while (crystal_out_clock_pin_oe !== 1'b1 && n < 40) begin @(posedge pclk); n++; end
		`CHK(crystal_out_clock_pin_oe, 1'b1)
		wr(TUNE_A, 32'h0000_0020);
		n = 0;
		while (crystal_out_clock_pin_oe !== 1'b0 && n < 40) begin @(posedge pclk); n++; end
		`CHK(crystal_out_clock_pin_oe, 1'b0)
		`CHK(crystal_out_clock_pin_o, 1'b0)
		wr(TUNE_A, 32'h0000_0060);
	endtask
	task automatic t_sources();
		int n;
		logic [1:0] s, g, x;
		for (int i = 0; i < 6; i++) begin
			s = (i == 2) ? 2'b11 : (i > 2) ? 2'b10 : 2'(i);
			g = 2'(i % 3);
			x = (s == 2'b10) ? g : 2'b11;
			source_config <= s; crystal_range_config <= g;
			do_reset(1'b0);
			wake_len((s == 2'b10) ? 992 : 224, per[s]);
			tick_gap(n);
			`CHK(n, per[s])
			src_gap(n);
			`CHK(n, per[s])
			`CHK(crystal_range, x)
			`CHK(crystal_osc_enable, s == 2'b10)
			`CHK(crystal_out_clock_pin_oe, s != 2'b10)
			wr(STAT_A, 32'h0000_00FF);
			rd(STAT_A, {25'h0, 1'b1, s != 2'b10, 1'b0, x, s}, 1'b0);
		end
	endtask
	task automatic t_divider();
		int n;
		wr(DIV_A, 32'h0000_0002);
		tick_gap(n);
		`CHK(n, 4 * 14)
		wake_request <= 1'b1;
		@(posedge pclk); wake_request <= 1'b0;
		@(posedge pclk);
		`CHK(cpu_clock_held, 1'b1)
		wake_len(992, 14);
		wr(DIV_A, 32'h0000_00FF);
		tick_gap(n);
		`CHK(n, 510 * 14)
		rd(DIV_A, 32'h0000_00FF, 1'b0);
	endtask
	initial begin
		presetn = 1'b0; por_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 12'h000; pwdata = 32'h0000_0000; rtc_uses_crystal = 1'b0; wake_request = 1'b0;
		source_config = 2'b01; crystal_range_config = 2'b00;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1; por_n <= 1'b1;
		t_regs(); t_clkout(); t_sources(); t_divider();
		tally_and_finish();
	end
endmodule // tb
bind mcu_clock_generation clock_gen_properties #(.TRIM_FACTORY(TRIM_FACTORY)) u_clock_gen_properties (.*);
